// File: verilog/sidec_pkg.sv
/*
 * Shared constants, command and pin types for the secondary IDE channel.
 * Assumes a 50 MHz mclk; all timing figures are converted to mclk cycles here.
 */
package sidec_pkg;

	// ==========================================================
	// Timing
	localparam int MCLK_PERIOD_NS = 20;
	localparam int T_SETUP_NS     = 70;
	localparam int T_ACTIVE_NS    = 165;
	localparam int T_RECOV_NS     = 30;
	localparam int T_UHALF_NS     = 60;
	localparam int T_STOP_NS      = 60;
	// Least times round up
	localparam int SETUP_CYC  = (T_SETUP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int ACTIVE_CYC = (T_ACTIVE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int RECOV_CYC  = (T_RECOV_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int UHALF_CYC  = (T_UHALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int STOP_CYC   = (T_STOP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

	// ==========================================================
	// Strobe rings
	localparam int         RING_AW     = 3;
	localparam logic [3:0] PAUSE_LEVEL = 4'h4;

	// ==========================================================
	// Commands
	typedef enum logic [2:0] {
		SIDEC_PIO_RD  = 3'h0,
		SIDEC_PIO_WR  = 3'h1,
		SIDEC_DMA_RD  = 3'h2,
		SIDEC_DMA_WR  = 3'h3,
		SIDEC_UDMA_RD = 3'h4,
		SIDEC_UDMA_WR = 3'h5
	} sidec_kind_t;

	typedef struct packed {
		sidec_kind_t kind;
		logic        ctrl_blk;
		logic [2:0]  addr;
		logic [15:0] wdata;
		logic [15:0] count;
	} sidec_cmd_t;

	// ==========================================================
	// Connector pin set
	typedef struct packed {
		logic        rd_n;
		logic        wr_n;
		logic        cs1_n;
		logic        cs3_n;
		logic        dack_n;
		logic [2:0]  addr;
		logic [15:0] dout;
		logic        doe_n;
	} sidec_pins_t;

	localparam sidec_pins_t PINS_RESET = '{
		rd_n: 1'b1, wr_n: 1'b1, cs1_n: 1'b1, cs3_n: 1'b1, dack_n: 1'b1,
		addr: 3'h0, dout: 16'h0000, doe_n: 1'b1
	};

endpackage

// File: verilog/sidec_strobe_ring.sv
/*
 * Capture ring written on one edge of the drive's read strobe.
 * Assumes the reader syncs wr_gray into its own clock and reads mem asynchronously.
 */
module sidec_strobe_ring (
	// Link side
	input  wire logic        strobe_clk,
	input  wire logic        rst,
	input  wire logic [15:0] din,
	// Reader side
	input  wire logic [2:0]  rd_addr,
	output logic      [15:0] rd_data,
	output logic      [3:0]  wr_gray
);

	// ==========================================================
	// Storage
	logic [15:0] mem [8];
	logic [3:0]  wbin_reg;
	logic [3:0]  wbin_next;
	logic [3:0]  gray_reg;

	assign wbin_next = wbin_reg + 4'h1;
	assign rd_data   = mem[rd_addr];
	assign wr_gray   = gray_reg;

	// No overflow guard: the drive pauses on DMARDY# long before eight words pile up
	always_ff @(posedge strobe_clk or posedge rst) begin
		if (rst) begin
			wbin_reg <= 4'h0;
			gray_reg <= 4'h0;
		end else begin
			wbin_reg <= wbin_next;
			gray_reg <= wbin_next ^ (wbin_next >> 1);
		end
	end

	always_ff @(posedge strobe_clk) begin
		mem[wbin_reg[2:0]] <= din; // [R10]
	end

endmodule

// File: verilog/sidec_channel.sv
/*
 * Secondary IDE channel host: PIO, multiword DMA and Ultra DMA/33 bursts.
 * Assumes udma_strobe_clk is the selected connector's ready pin, used as a clock.
 */
// Contract
// (R1) Drive raises DMA request to ask for transfer; bus-master only, no legacy channel.
// (R2) Normal mode: host lowers read strobe so drive places word on data lines.
// (R3) Normal mode: host latches read data as its read strobe rises.
// (R4) Normal mode: drive latches write data as host write strobe rises.
// (R5) Drive addressed by chip selects plus address, or by DMA acknowledge.
// (R6) Ultra read: read strobe pin is DMARDY#, host negates it to pause.
// (R7) Ultra write: host toggles read strobe pin; drive latches each edge.
// (R8) Ultra read and write: write strobe pin is STOP, asserted to end.
// (R9) Normal mode: drive's IORDY on ready pin lets it stretch cycles.
// (R10) Ultra read: drive toggles ready pin; host latches a word per edge.
// (R11) Ultra write: drive negates ready pin as DMARDY# to pause host.
// (R12) Signals go to secondary connector, or to primary slave when configured.
// (R13) Read and write strobes stay high during and after reset.
// (R14) Undefined primary pins take the secondary pins' reset values.
// (R15) DMA acknowledge marks the strobe cycle as a DMA transfer.
// (R16) Command select for 170H-177H, control select for 370H-377H.
// (R17) Sender stops strobing while DMARDY# negated, resumes on reassertion.
module sidec_channel (
	// Clocks and reset
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire logic                 udma_strobe_clk,
	// Configuration
	input  wire logic                 primary_slave_mode,
	// Command port
	input  wire sidec_pkg::sidec_cmd_t cmd,
	input  wire logic                 cmd_valid,
	output logic                      cmd_ready,
	output logic                      busy,
	// Ultra write data stream
	input  wire logic [15:0]          udma_wdata,
	input  wire logic                 udma_wvalid,
	output logic                      udma_wready,
	// Read data stream
	output logic      [15:0]          rd_data,
	output logic                      rd_valid,
	input  wire logic                 rd_ready,
	// Secondary connector
	input  wire logic                 sec_dma_request,
	input  wire logic                 sec_channel_ready,
	input  wire logic [15:0]          sec_disk_data_in,
	output logic      [15:0]          sec_disk_data_out,
	output logic                      sec_disk_data_oe_n,
	output logic                      sec_read_strobe_n,
	output logic                      sec_write_strobe_n,
	output logic                      sec_cmd_block_select_n,
	output logic                      sec_ctrl_block_select_n,
	output logic                      sec_dma_ack_n,
	output logic      [2:0]           sec_disk_addr,
	// Primary slave connector
	input  wire logic                 ps_dma_request,
	input  wire logic                 ps_channel_ready,
	input  wire logic [15:0]          ps_disk_data_in,
	output logic      [15:0]          ps_disk_data_out,
	output logic                      ps_disk_data_oe_n,
	output logic                      ps_read_strobe_n,
	output logic                      ps_write_strobe_n,
	output logic                      ps_cmd_block_select_n,
	output logic                      ps_ctrl_block_select_n,
	output logic                      ps_dma_ack_n,
	output logic      [2:0]           ps_disk_addr
);

	// ==========================================================
	// State
	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_SETUP   = 3'h1,
		ST_ACTIVE  = 3'h2,
		ST_RECOVER = 3'h3,
		ST_URD     = 3'h4,
		ST_UWR     = 3'h5,
		ST_USTOP   = 3'h6
	} sidec_state_t;

	sidec_state_t           state_reg, state_next;
	sidec_pkg::sidec_kind_t kind_reg, kind_next;
	sidec_pkg::sidec_pins_t pins_reg, pins_next;
	logic [7:0]             timer_reg, timer_next;
	logic [15:0]            remaining_reg, remaining_next;
	logic                   phase_reg, phase_next;
	logic                   sel_reg, sel_next;
	logic                   mode_reg;
	logic [15:0]            rd_data_reg, rd_data_next;
	logic                   rd_valid_reg, rd_valid_next;
	logic [3:0]             rptr_reg [2];
	logic [3:0]             rptr_next [2];

	// ==========================================================
	// Connector selection
	wire        dmarq_pin = mode_reg ? ps_dma_request : sec_dma_request;    // [R12]
	wire        ready_pin = mode_reg ? ps_channel_ready : sec_channel_ready;
	wire [15:0] data_pin  = mode_reg ? ps_disk_data_in : sec_disk_data_in;

	// Unused set parks at the secondary reset values
	wire sidec_pkg::sidec_pins_t sec_pins = mode_reg ? sidec_pkg::PINS_RESET : pins_reg; // [R12]
	wire sidec_pkg::sidec_pins_t ps_pins  = mode_reg ? pins_reg : sidec_pkg::PINS_RESET; // [R14]

	assign sec_disk_data_out       = sec_pins.dout;
	assign sec_disk_data_oe_n      = sec_pins.doe_n;
	assign sec_read_strobe_n       = sec_pins.rd_n;
	assign sec_write_strobe_n      = sec_pins.wr_n;
	assign sec_cmd_block_select_n  = sec_pins.cs1_n;
	assign sec_ctrl_block_select_n = sec_pins.cs3_n;
	assign sec_dma_ack_n           = sec_pins.dack_n;
	assign sec_disk_addr           = sec_pins.addr;
	assign ps_disk_data_out        = ps_pins.dout;
	assign ps_disk_data_oe_n       = ps_pins.doe_n;
	assign ps_read_strobe_n        = ps_pins.rd_n;
	assign ps_write_strobe_n       = ps_pins.wr_n;
	assign ps_cmd_block_select_n   = ps_pins.cs1_n;
	assign ps_ctrl_block_select_n  = ps_pins.cs3_n;
	assign ps_dma_ack_n            = ps_pins.dack_n;
	assign ps_disk_addr            = ps_pins.addr;

	// ==========================================================
	// Pin synchronisers
	logic [17:0] sync1_reg, sync2_reg;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sync1_reg <= 18'h00000;
			sync2_reg <= 18'h00000;
		end else begin
			sync1_reg <= {dmarq_pin, ready_pin, data_pin};
			sync2_reg <= sync1_reg;
		end
	end

	wire        dmarq_s = sync2_reg[17];
	wire        ready_s = sync2_reg[16];
	wire [15:0] data_s  = sync2_reg[15:0];

	// ==========================================================
	// Ultra read capture, one ring per strobe edge
	logic [15:0] ring_data [2];
	logic [3:0]  ring_gray [2];
	logic [3:0]  gsync1_reg [2];
	logic [3:0]  gsync2_reg [2];
	logic [3:0]  wbin [2];
	logic [3:0]  fill [2];

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ring
			wire ring_clk = (gi == 0) ? udma_strobe_clk : ~udma_strobe_clk;

			sidec_strobe_ring u_ring (
				.strobe_clk (ring_clk),
				.rst        (rst),
				.din        (data_pin),
				.rd_addr    (rptr_reg[gi][2:0]),
				.rd_data    (ring_data[gi]),
				.wr_gray    (ring_gray[gi])
			);

			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					gsync1_reg[gi] <= 4'h0;
					gsync2_reg[gi] <= 4'h0;
					rptr_reg[gi]   <= 4'h0;
				end else begin
					gsync1_reg[gi] <= ring_gray[gi];
					gsync2_reg[gi] <= gsync1_reg[gi];
					rptr_reg[gi]   <= rptr_next[gi];
				end
			end

			assign wbin[gi] = gsync2_reg[gi] ^ (gsync2_reg[gi] >> 1) ^
				(gsync2_reg[gi] >> 2) ^ (gsync2_reg[gi] >> 3);
			assign fill[gi] = wbin[gi] - rptr_reg[gi];
		end
	endgenerate

	// ==========================================================
	// Decode
	wire cmd_is_udma  = (cmd.kind == sidec_pkg::SIDEC_UDMA_RD) ||
		(cmd.kind == sidec_pkg::SIDEC_UDMA_WR);
	wire cmd_is_dma   = cmd_is_udma || (cmd.kind == sidec_pkg::SIDEC_DMA_RD) ||
		(cmd.kind == sidec_pkg::SIDEC_DMA_WR);
	wire cmd_is_read  = (cmd.kind == sidec_pkg::SIDEC_PIO_RD) ||
		(cmd.kind == sidec_pkg::SIDEC_DMA_RD);
	wire cmd_is_write = (cmd.kind == sidec_pkg::SIDEC_PIO_WR) ||
		(cmd.kind == sidec_pkg::SIDEC_DMA_WR);
	wire kind_is_read = (kind_reg == sidec_pkg::SIDEC_PIO_RD) ||
		(kind_reg == sidec_pkg::SIDEC_DMA_RD);
	wire timer_done   = (timer_reg == 8'h00);
	wire out_free     = !rd_valid_reg || rd_ready;
	// Pause early: the drive may still send a few edges after DMARDY# rises
	wire pause        = (fill[0] >= sidec_pkg::PAUSE_LEVEL) ||
		(fill[1] >= sidec_pkg::PAUSE_LEVEL);
	wire pop          = (state_reg == ST_URD) && (remaining_reg != 16'h0000) &&
		(fill[sel_reg] != 4'h0) && out_free;
	wire wr_slot      = (state_reg == ST_UWR) && timer_done && !ready_s &&
		(remaining_reg != 16'h0000);

	// DMA transfers wait for the drive's request; PIO and DMA reads wait for a free output
	assign cmd_ready   = (state_reg == ST_IDLE) && (!cmd_is_dma || dmarq_s) && // [R1]
		!(cmd_is_read && rd_valid_reg);
	assign udma_wready = wr_slot && !phase_reg; // [R17]
	assign busy        = (state_reg != ST_IDLE);
	assign rd_data     = rd_data_reg;
	assign rd_valid    = rd_valid_reg;

	// ==========================================================
	// Sequencer
	always_comb begin
		state_next     = state_reg;
		kind_next      = kind_reg;
		pins_next      = pins_reg;
		timer_next     = timer_done ? timer_reg : timer_reg - 8'h01;
		remaining_next = remaining_reg;
		phase_next     = phase_reg;
		sel_next       = sel_reg;
		rd_data_next   = rd_data_reg;
		rd_valid_next  = rd_valid_reg && !rd_ready;
		rptr_next      = rptr_reg;
		case (state_reg)
			ST_IDLE: if (cmd_valid && cmd_ready) begin
				kind_next      = cmd.kind;
				remaining_next = cmd.count;
				pins_next.addr = cmd.addr;
				if (cmd_is_dma) begin
					pins_next.dack_n = 1'b0; // [R15] [R5]
				end else begin
					pins_next.cs1_n = cmd.ctrl_blk;  // [R16] [R5]
					pins_next.cs3_n = !cmd.ctrl_blk; // [R16]
				end
				if (cmd.kind == sidec_pkg::SIDEC_UDMA_RD) begin
					pins_next.wr_n = 1'b0;
					rptr_next      = wbin; // Drop stray edges from a previous burst
					sel_next       = 1'b0;
					state_next     = ST_URD;
				end else if (cmd.kind == sidec_pkg::SIDEC_UDMA_WR) begin
					pins_next.wr_n  = 1'b0;
					pins_next.doe_n = 1'b0;
					phase_next      = 1'b0;
					timer_next      = 8'h00;
					state_next      = ST_UWR;
				end else begin
					pins_next.dout  = cmd.wdata;
					pins_next.doe_n = !cmd_is_write;
					timer_next      = 8'(sidec_pkg::SETUP_CYC);
					state_next      = ST_SETUP;
				end
			end
			ST_SETUP: if (timer_done) begin
				pins_next.rd_n = !kind_is_read; // [R2]
				pins_next.wr_n = kind_is_read;  // [R4]
				timer_next     = 8'(sidec_pkg::ACTIVE_CYC);
				state_next     = ST_ACTIVE;
			end
			ST_ACTIVE: if (timer_done && ready_s) begin // [R9]
				pins_next.rd_n = 1'b1;
				pins_next.wr_n = 1'b1; // [R4]
				if (kind_is_read) begin
					rd_data_next  = data_s; // [R3]
					rd_valid_next = 1'b1;
				end
				timer_next = 8'(sidec_pkg::RECOV_CYC);
				state_next = ST_RECOVER;
			end
			ST_RECOVER: if (timer_done) begin
				pins_next  = sidec_pkg::PINS_RESET;
				state_next = ST_IDLE;
			end
			ST_URD: begin
				pins_next.rd_n = pause; // [R6]
				if (pop) begin
					rd_data_next       = ring_data[sel_reg]; // [R10]
					rd_valid_next      = 1'b1;
					rptr_next[sel_reg] = rptr_reg[sel_reg] + 4'h1;
					sel_next           = !sel_reg;
					remaining_next     = remaining_reg - 16'h0001;
				end
				if (remaining_reg == 16'h0000) begin
					pins_next.wr_n = 1'b1; // [R8]
					pins_next.rd_n = 1'b1;
					timer_next     = 8'(sidec_pkg::STOP_CYC);
					state_next     = ST_USTOP;
				end
			end
			ST_UWR: begin
				if (wr_slot && !phase_reg && udma_wvalid) begin
					pins_next.dout = udma_wdata;
					phase_next     = 1'b1;
					timer_next     = 8'(sidec_pkg::UHALF_CYC);
				end else if (wr_slot && phase_reg) begin
					pins_next.rd_n = !pins_reg.rd_n; // [R7] [R11] [R17]
					phase_next     = 1'b0;
					remaining_next = remaining_reg - 16'h0001;
					timer_next     = 8'(sidec_pkg::UHALF_CYC);
				end
				if (remaining_reg == 16'h0000 && timer_done) begin
					pins_next.wr_n = 1'b1; // [R8]
					pins_next.rd_n = 1'b1;
					timer_next     = 8'(sidec_pkg::STOP_CYC);
					state_next     = ST_USTOP;
				end
			end
			ST_USTOP: if (timer_done) begin
				pins_next.dack_n = 1'b1;
				pins_next.doe_n  = 1'b1;
				timer_next       = 8'(sidec_pkg::RECOV_CYC);
				state_next       = ST_RECOVER;
			end
			default: begin
				pins_next  = sidec_pkg::PINS_RESET;
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg     <= ST_IDLE;
			kind_reg      <= sidec_pkg::SIDEC_PIO_RD;
			pins_reg      <= sidec_pkg::PINS_RESET; // [R13] [R14]
			timer_reg     <= 8'h00;
			remaining_reg <= 16'h0000;
			phase_reg     <= 1'b0;
			sel_reg       <= 1'b0;
			rd_data_reg   <= 16'h0000;
			rd_valid_reg  <= 1'b0;
		end else begin
			state_reg     <= state_next;
			kind_reg      <= kind_next;
			pins_reg      <= pins_next;
			timer_reg     <= timer_next;
			remaining_reg <= remaining_next;
			phase_reg     <= phase_next;
			sel_reg       <= sel_next;
			rd_data_reg   <= rd_data_next;
			rd_valid_reg  <= rd_valid_next;
		end
	end

	// Connector choice only changes between transfers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_reg <= 1'b0;
		end else if (state_reg == ST_IDLE) begin
			mode_reg <= primary_slave_mode; // [R12]
		end
	end

endmodule

// File: verif/sidec_monitor.sv
/*
 * Port-level checker for the secondary IDE channel host.
 * Assumes active-high async rst and mclk-domain ports.
 */
module sidec_monitor (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// Command side
	input wire logic        primary_slave_mode,
	input wire logic        busy,
	input wire logic        rd_valid,
	// Secondary connector
	input wire logic [15:0] sec_disk_data_out,
	input wire logic        sec_disk_data_oe_n,
	input wire logic        sec_read_strobe_n,
	input wire logic        sec_write_strobe_n,
	input wire logic        sec_cmd_block_select_n,
	input wire logic        sec_ctrl_block_select_n,
	input wire logic        sec_dma_ack_n,
	// Primary slave connector
	input wire logic        ps_read_strobe_n,
	input wire logic        ps_write_strobe_n,
	input wire logic        ps_cmd_block_select_n,
	input wire logic        ps_ctrl_block_select_n,
	input wire logic        ps_dma_ack_n
);
	timeunit 1ns / 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// ==========================================================
	// Sequences
	sequence s_rd_active;
		!sec_read_strobe_n [*8];
	endsequence
	sequence s_wr_pace;
		$stable(sec_read_strobe_n) [*2];
	endsequence
	// Ack release has slack; it must come 2 to 5 cycles after STOP rises
	sequence s_stop_tail;
		(sec_write_strobe_n && !sec_dma_ack_n) [*2] ##[1:4] sec_dma_ack_n;
	endsequence

	// ==========================================================
	// Assertions
	a_strobes_reset_high: assert property ($fell(rst) |->
		sec_read_strobe_n && sec_write_strobe_n && sec_dma_ack_n
		&& ps_read_strobe_n && ps_write_strobe_n && ps_dma_ack_n)
		else $error("strobe or ack low after reset");
	a_sec_parked: assert property (busy && primary_slave_mode |->
		sec_read_strobe_n && sec_write_strobe_n && sec_dma_ack_n
		&& sec_cmd_block_select_n && sec_ctrl_block_select_n)
		else $error("sec pins active in ps mode");
	a_ps_parked: assert property (busy && !primary_slave_mode |->
		ps_read_strobe_n && ps_write_strobe_n && ps_dma_ack_n
		&& ps_cmd_block_select_n && ps_ctrl_block_select_n)
		else $error("ps pins active in sec mode");
	a_cycle_addressed: assert property ($fell(sec_read_strobe_n) || $fell(sec_write_strobe_n)
		|-> !sec_dma_ack_n || (sec_cmd_block_select_n != sec_ctrl_block_select_n))
		else $error("strobe cycle not addressed");
	a_read_captured: assert property ($rose(sec_read_strobe_n) && sec_write_strobe_n
		&& $past(sec_write_strobe_n, 2) |-> ##[0:2] rd_valid)
		else $error("no read word after strobe");
	a_active_width: assert property ($fell(sec_read_strobe_n) && sec_write_strobe_n
		|-> s_rd_active)
		else $error("read strobe too short");
	a_write_data_held: assert property (!sec_write_strobe_n && sec_read_strobe_n
		&& !(sec_cmd_block_select_n && sec_ctrl_block_select_n)
		|-> !sec_disk_data_oe_n && $stable(sec_disk_data_out))
		else $error("write data not held");
	a_stop_ends_burst: assert property ($rose(sec_write_strobe_n) && !sec_dma_ack_n
		&& sec_disk_data_oe_n |-> s_stop_tail)
		else $error("ack released before stop");
	a_udma_wr_pace: assert property ($changed(sec_read_strobe_n) && !sec_write_strobe_n
		&& !sec_disk_data_oe_n && !sec_dma_ack_n |=> s_wr_pace)
		else $error("ultra strobe too fast");
endmodule

bind sidec_channel sidec_monitor sidec_monitor_inst (
	.mclk, .rst, .primary_slave_mode, .busy, .rd_valid, .sec_disk_data_out,
	.sec_disk_data_oe_n, .sec_read_strobe_n, .sec_write_strobe_n, .sec_cmd_block_select_n,
	.sec_ctrl_block_select_n, .sec_dma_ack_n, .ps_read_strobe_n, .ps_write_strobe_n,
	.ps_cmd_block_select_n, .ps_ctrl_block_select_n, .ps_dma_ack_n
);

// File: verif/sidec_drive_model.sv
/*
 * Behavioural disk drive on one connector of the channel.
 * Assumes mode inputs settle before each command; lclk period 48 ns.
 */
module sidec_drive_model (
	// Timebase and bench controls
	input  wire logic                   lclk,
	input  wire logic                   udma,
	input  wire logic                   dir_rd,
	input  wire logic                   pause,
	input  wire logic                   slow,
	input  wire logic                   req,
	input  wire logic [15:0]            base,
	input  wire logic [15:0]            n_words,
	// Host pins
	input  wire sidec_pkg::sidec_pins_t pins,
	// Drive pins
	output logic                        dma_request,
	output logic                        channel_ready,
	output logic      [15:0]            bus
);
	timeunit 1ns / 1ns;
	logic [4:0]  key;
	logic [15:0] word;
	logic [15:0] last;
	logic [15:0] sent;
	logic [20:0] last_w;
	logic [15:0] rx [$];
	logic        strb;
	logic        iordy;
	logic        drv;

	// ==========================================================
	// Pin levels
	assign key = !pins.dack_n ? 5'h10 : {1'b0, !pins.cs3_n, pins.addr};
	assign dma_request = req;
	assign drv = udma ? (dir_rd && !pins.dack_n && !pins.wr_n)
		: (!pins.rd_n && !(pins.dack_n && pins.cs1_n && pins.cs3_n));
	assign word = udma ? base + sent : base + {11'h0, key};
	// Released bus shows the inverse of the last word
	assign bus = !pins.doe_n ? pins.dout : (drv ? word : ~last);
	assign channel_ready = udma ? (dir_rd ? strb : pause) : iordy;

	initial {strb, iordy, sent, last} = {2'b01, 32'h0};

	// ==========================================================
	// Transfers
	always @(posedge lclk) begin
		if (drv)
			last <= word;
		if (pins.dack_n)
			strb <= 1'b0;
		else if (udma && dir_rd && !pins.wr_n && !pins.rd_n && sent < n_words)
			strb <= !strb;
	end
	// Word advances half a period after its edge, so it is held around it
	always @(negedge lclk) begin
		if (pins.dack_n)
			sent <= 16'h0;
		else if (strb != sent[0])
			sent <= sent + 16'h1;
	end
	always @(pins.rd_n) begin
		if (udma && !dir_rd && !pins.dack_n && !pins.wr_n)
			rx.push_back(bus);
	end
	always @(posedge pins.wr_n) begin
		if (!udma)
			last_w = {key, bus};
	end
	always @(negedge pins.rd_n or negedge pins.wr_n) begin
		if (!udma && slow) begin
			iordy = 1'b0;
			#400;
			iordy = 1'b1;
		end
	end
endmodule

// File: verif/testbench.sv
/*
 * Self-checking bench for the secondary IDE channel host.
 * Assumes one drive model per connector, both on shared mode controls.
 */
module testbench;
	timeunit 1ns / 1ns;
	logic                        mclk, lclk, rst, psm, cmd_valid, rd_ready, stall;
	logic                        udma_wvalid, udma, dir_rd, pause, slow, req;
	logic [15:0]                 udma_wdata, base, wi, nw, lo_t, w;
	logic [31:0]                 seed, err_count, checks_done, cycles, n0;
	logic [2:0]                  a;
	time                         t_fall;
	sidec_pkg::sidec_cmd_t       cmd;
	wire logic                   cmd_ready, busy, udma_wready, rd_valid;
	wire logic                   s_req, s_rdy, p_req, p_rdy;
	wire logic [15:0]            rd_data, s_bus, p_bus;
	wire sidec_pkg::sidec_pins_t sp, pp;
	logic [15:0]                 rdq [$];

	// ==========================================================
	// Clocks and instances
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		lclk = 1'b0;
		#7;
		forever #24 lclk = ~lclk;
	end
	sidec_channel sidec_channel_inst (
		.mclk, .rst, .udma_strobe_clk(psm ? p_rdy : s_rdy), .primary_slave_mode(psm), .cmd,
		.cmd_valid, .cmd_ready, .busy, .udma_wdata, .udma_wvalid, .udma_wready, .rd_data,
		.rd_valid, .rd_ready,
		.sec_dma_request(s_req), .sec_channel_ready(s_rdy), .sec_disk_data_in(s_bus),
		.sec_disk_data_out(sp.dout), .sec_disk_data_oe_n(sp.doe_n), .sec_read_strobe_n(sp.rd_n),
		.sec_write_strobe_n(sp.wr_n), .sec_cmd_block_select_n(sp.cs1_n),
		.sec_ctrl_block_select_n(sp.cs3_n), .sec_dma_ack_n(sp.dack_n), .sec_disk_addr(sp.addr),
		.ps_dma_request(p_req), .ps_channel_ready(p_rdy), .ps_disk_data_in(p_bus),
		.ps_disk_data_out(pp.dout), .ps_disk_data_oe_n(pp.doe_n), .ps_read_strobe_n(pp.rd_n),
		.ps_write_strobe_n(pp.wr_n), .ps_cmd_block_select_n(pp.cs1_n),
		.ps_ctrl_block_select_n(pp.cs3_n), .ps_dma_ack_n(pp.dack_n), .ps_disk_addr(pp.addr));
	sidec_drive_model sec_drive (.lclk, .udma, .dir_rd, .pause, .slow, .req, .base,
		.n_words(nw), .pins(sp), .dma_request(s_req), .channel_ready(s_rdy), .bus(s_bus));
	sidec_drive_model ps_drive (.lclk, .udma, .dir_rd, .pause, .slow, .req, .base,
		.n_words(nw), .pins(pp), .dma_request(p_req), .channel_ready(p_rdy), .bus(p_bus));

	// ==========================================================
	// Streams, timeout, strobe timing
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (rd_valid === 1'b1 && rd_ready)
			rdq.push_back(rd_data);
		if (udma_wready === 1'b1 && udma_wvalid)
			wi <= wi + 16'h1;
		if (cycles == 32'h0000_4e20) begin
			err_count++;
			end_of_test;
		end
	end
	always @(negedge mclk) begin
		rd_ready = stall ? 1'b0 : 1'($random(seed));
		udma_wdata = base + wi;
		udma_wvalid = !dir_rd && wi < nw;
	end
	always @(negedge sp.rd_n) t_fall = $time;
	always @(posedge sp.rd_n) lo_t = 16'($time - t_fall);

	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic run(input sidec_pkg::sidec_kind_t k, input logic c, input logic [15:0] n);
		@(negedge mclk);
		cmd = '{k, c, a, base, n};
		cmd_valid = 1'b1;
		for (int t = 0; cmd_ready !== 1'b1 && t < 300; t++) @(negedge mclk);
		@(negedge mclk);
		cmd_valid = 1'b0;
		for (int t = 0; busy !== 1'b0 && t < 4000; t++) @(negedge mclk);
	endtask
	task automatic get;
		for (int t = 0; rdq.size() == 0 && t < 200; t++) @(negedge mclk);
		w = rdq.size() ? rdq.pop_front() : 16'hxxxx;
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	initial begin
		{seed, err_count, checks_done, cycles} = {32'hb68d, 96'h0};
		{rst, psm, cmd_valid, stall, udma, dir_rd, pause, slow, req, rd_ready, udma_wvalid} = 11'h400;
		{cmd, udma_wdata, base, wi, nw, a} = '0;
		repeat (6) @(posedge mclk);
		chk("pins_in_reset", sidec_pkg::PINS_RESET, sp);
		@(negedge mclk);
		rst = 1'b0;
		chk("sec_pins", sidec_pkg::PINS_RESET, sp);
		chk("ps_pins", sidec_pkg::PINS_RESET, pp);
		for (int i = 0; i < 8; i++) begin
			slow = (i == 3);
			base = 16'($random(seed));
			a = 3'($random(seed));
			run(sidec_pkg::SIDEC_PIO_WR, i[0], 16'h0);
			chk("pio_wr", {1'b0, i[0], a, base}, sec_drive.last_w);
			run(sidec_pkg::SIDEC_PIO_RD, i[0], 16'h0);
			get;
			chk("pio_rd", base + {i[0], a}, w);
			if (slow) chk("stretch", 1, lo_t >= 16'd400);
		end
		$display("pio test done");
		a = 3'h0;
		run(sidec_pkg::SIDEC_DMA_RD, 1'b0, 16'h0);
		chk("refused", 0, busy);
		req = 1'b1;
		base = 16'($random(seed));
		run(sidec_pkg::SIDEC_DMA_WR, 1'b0, 16'h0);
		chk("dma_wr", {5'h10, base}, sec_drive.last_w);
		run(sidec_pkg::SIDEC_DMA_RD, 1'b0, 16'h0);
		get;
		chk("dma_rd", base + 16'h10, w);
		$display("dma test done");
		{udma, dir_rd, nw, base} = {2'b11, 16'h10, 16'($random(seed))};
		repeat (4) @(negedge mclk);
		stall = 1'b1;
		fork
			run(sidec_pkg::SIDEC_UDMA_RD, 1'b0, 16'h10);
			begin
				repeat (80) @(negedge mclk);
				chk("paused", 1, sec_drive.sent < 16'h10);
				stall = 1'b0;
			end
		join
		for (int i = 0; i < 16; i++) begin
			get;
			chk("udma_rd", base + 16'(i), w);
		end
		$display("ultra read test done");
		{dir_rd, nw, wi, base} = {1'b0, 16'h8, 16'h0, 16'($random(seed))};
		sec_drive.rx.delete();
		fork
			run(sidec_pkg::SIDEC_UDMA_WR, 1'b0, 16'h8);
			begin
				repeat (12) @(negedge mclk);
				pause = 1'b1;
				repeat (6) @(negedge mclk);
				n0 = sec_drive.rx.size();
				repeat (20) @(negedge mclk);
				chk("held", n0, sec_drive.rx.size());
				pause = 1'b0;
			end
		join
		chk("udma_wr_n", 8, sec_drive.rx.size());
		foreach (sec_drive.rx[i]) chk("udma_wr", base + 16'(i), sec_drive.rx[i]);
		$display("ultra write test done");
		{udma, psm, a, base} = {2'b01, 3'h5, 16'($random(seed))};
		repeat (4) @(negedge mclk);
		run(sidec_pkg::SIDEC_PIO_WR, 1'b1, 16'h0);
		chk("ps_wr", {5'h0d, base}, ps_drive.last_w);
		run(sidec_pkg::SIDEC_PIO_RD, 1'b1, 16'h0);
		get;
		chk("ps_rd", base + 16'hd, w);
		$display("primary slave test done");
		end_of_test;
	end
endmodule
